/* File: verilog/rcg_top.sv */
// Ranging code generator: common and variant registers, overlays.
// Assumes nav_bit_train and satellite selection are on clk.
`default_nettype none

module rcg_top
  import rcg_pkg::*;
#(
  parameter int EPOCH_LEN = EPOCH_CHIPS,
  parameter int XA_CUT    = XA_LEN
) (
  // Clock and reset
  input  wire logic      clk,
  input  wire logic      reset_n,
  // Control from the payload controller
  input  wire logic      gen_enable,
  input  wire rcg_sat_t  sat_sel,
  // Navigation data source
  input  wire logic      nav_bit_train,
  output logic           symbol_take_ff,
  // Carrier modulator
  output rcg_chip_t      chips_ff,
  output logic           chip_strobe_ff,
  output logic           epoch_pulse_ff,
  output logic           running_ff
);

  // ==========================================================
  // Elaboration checks
  if (EPOCH_LEN <= XA_CUT || EPOCH_LEN >= 2 ** CNT_W)
    $error("EPOCH_LEN out of range");
  if (XA_CUT < 2 || XA_CUT > XB_LEN)
    $error("XA_CUT out of range");

  // ==========================================================
  // Chip clock enable
  // Phase accumulator keeps the mean chip rate exact; edges jitter
  // by one clock, but both codes share the same enable.
  logic [NCO_W-1:0] acc_ff;
  logic             chip_en_ff;
  wire logic [NCO_W:0] acc_sum = {1'b0, acc_ff} + {1'b0, NCO_INC};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_ff     <= '0;
      chip_en_ff <= 1'b0;
    end else begin
      acc_ff     <= acc_sum[NCO_W-1:0];
      chip_en_ff <= acc_sum[NCO_W];               // see [R15]
    end
  end

  // ==========================================================
  // Sequencer state and counters
  rcg_state_t       state_ff;
  logic [12:0]      b0i_ff, b0q_ff;
  logic [12:0]      seek_i_ff, seek_q_ff;
  logic [CNT_W-1:0] chip_cnt_ff, xa_cnt_ff;
  logic [3:0]       ovl_cnt_ff;
  logic [4:0]       qs_cnt_ff;
  logic             sym_ff;

  // Printed vectors list stage 13 rightmost; flip into stage order
  function automatic logic [12:0] rcg_flip(input logic [12:0] v);
    logic [12:0] r;
    r = '0;
    for (int k = 0; k < 13; k++) begin
      r[k] = v[12-k];                             // see [R18]
    end
    return r;
  endfunction

  // Decodes
  wire logic run       = (state_ff == RCG_RUN);
  wire logic seek      = (state_ff == RCG_SEEK);
  wire logic in_load   = (state_ff == RCG_LOAD);
  wire logic tick      = run && chip_en_ff;
  wire logic epoch_end = (chip_cnt_ff == CNT_W'(EPOCH_LEN - 1));
  wire logic xa_end    = (xa_cnt_ff == CNT_W'(XA_CUT - 1));
  wire logic ovl_end   = (ovl_cnt_ff == 4'(OVL_LEN - 1));
  wire logic qs_end    = (qs_cnt_ff == 5'(QSYNC_LEN - 1));
  wire logic go_seek   = (state_ff == RCG_IDLE) && gen_enable
                         && sat_sel.use_advance;
  wire logic seek_done = seek && seek_i_ff == '0 && seek_q_ff == '0;

  // ==========================================================
  // Shift register generators
  logic [12:0] xa_st, xbi_st, xbq_st;
  logic        xa_out, xbi_out, xbq_out;

  // Common register: all ones at start, cut short, reset at epoch
  wire logic xa_load = in_load || (tick && (epoch_end || xa_end)); // see [R3]
  // Variants: free-running; only the epoch or set-up reloads them
  wire logic xb_load = go_seek || in_load || (tick && epoch_end);  // see [R6]
  wire logic [12:0] xbi_val = go_seek ? ALL_ONES : b0i_ff;
  wire logic [12:0] xbq_val = go_seek ? ALL_ONES : b0q_ff;
  wire logic xbi_step = tick || (seek && seek_i_ff != '0);         // see [R8]
  wire logic xbq_step = tick || (seek && seek_q_ff != '0);         // see [R5]

  rcg_lfsr13 #(.TAPS(XA_TAPS)) u_common (
    .clk        (clk),
    .reset_n    (reset_n),
    .load       (xa_load),
    .load_state (ALL_ONES),                       // see [R10]
    .step       (tick),
    .state_ff   (xa_st),
    .code_out   (xa_out)
  );

  rcg_lfsr13 #(.TAPS(XB_TAPS)) u_inphase (
    .clk        (clk),
    .reset_n    (reset_n),
    .load       (xb_load),
    .load_state (xbi_val),
    .step       (xbi_step),
    .state_ff   (xbi_st),
    .code_out   (xbi_out)
  );

  rcg_lfsr13 #(.TAPS(XB_TAPS)) u_quad (
    .clk        (clk),
    .reset_n    (reset_n),
    .load       (xb_load),
    .load_state (xbq_val),
    .step       (xbq_step),
    .state_ff   (xbq_st),
    .code_out   (xbq_out)
  );

  // ==========================================================
  // Chip composition
  wire logic i_code  = xa_out ^ xbi_out;          // see [R1]
  wire logic q_code  = xa_out ^ xbq_out;          // see [R1]
  wire logic ovl_bit = OVL_PATTERN[4'(OVL_LEN - 1) - ovl_cnt_ff];
  wire logic qs_bit  = QSYNC_PATTERN[5'(QSYNC_LEN - 1) - qs_cnt_ff];
  wire logic i_data  = sym_ff ^ ovl_bit;          // see [R16]
  wire rcg_chip_t nxt_chips = '{
    inphase_ranging_code:    i_code,
    quadrature_ranging_code: q_code,
    inphase_bit_train:       i_code ^ i_data,     // see [R11]
    quad_bit_train:          q_code ^ qs_bit      // see [R13]
  };

  // ==========================================================
  // Sequencer; satellite selection is sampled at enable
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff  <= RCG_IDLE;
      b0i_ff    <= ALL_ONES;
      b0q_ff    <= ALL_ONES;
      seek_i_ff <= '0;
      seek_q_ff <= '0;
    end else if (!gen_enable) begin
      state_ff  <= RCG_IDLE;
    end else begin
      case (state_ff)
        RCG_IDLE: begin
          if (sat_sel.use_advance) begin          // see [R19]
            seek_i_ff <= sat_sel.inphase_adv;
            seek_q_ff <= sat_sel.quad_adv;
            state_ff  <= RCG_SEEK;
          end else begin
            b0i_ff    <= rcg_flip(sat_sel.inphase_vec);
            b0q_ff    <= rcg_flip(sat_sel.quad_vec);
            state_ff  <= RCG_LOAD;
          end
        end
        RCG_SEEK: begin
          if (seek_i_ff != '0) seek_i_ff <= seek_i_ff - 13'h0001;
          if (seek_q_ff != '0) seek_q_ff <= seek_q_ff - 13'h0001;
          if (seek_done) begin
            b0i_ff   <= xbi_st;                   // see [R8]
            b0q_ff   <= xbq_st;
            state_ff <= RCG_LOAD;
          end
        end
        RCG_LOAD: state_ff <= RCG_RUN;
        default:  state_ff <= RCG_RUN;
      endcase
    end
  end

  // ==========================================================
  // Chip, epoch, overlay and sync counters
  // Counters clear together so the sync code starts on a data bit.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chip_cnt_ff <= '0;
      xa_cnt_ff   <= '0;
      ovl_cnt_ff  <= '0;
      qs_cnt_ff   <= '0;
      sym_ff      <= 1'b0;
    end else if (in_load) begin
      chip_cnt_ff <= '0;
      xa_cnt_ff   <= '0;
      ovl_cnt_ff  <= '0;
      qs_cnt_ff   <= '0;                          // see [R17]
      sym_ff      <= nav_bit_train;
    end else if (tick) begin
      chip_cnt_ff <= epoch_end ? '0 : chip_cnt_ff + 1'b1;    // see [R4]
      xa_cnt_ff   <= (epoch_end || xa_end) ? '0 : xa_cnt_ff + 1'b1;
      if (epoch_end) begin
        ovl_cnt_ff <= ovl_end ? '0 : ovl_cnt_ff + 4'h1;      // see [R12]
        qs_cnt_ff  <= qs_end ? '0 : qs_cnt_ff + 5'h01;       // see [R13]
        if (ovl_end) sym_ff <= nav_bit_train;                // see [R11]
      end
    end
  end

  // ==========================================================
  // Output registers, all updated on the same edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chips_ff       <= '0;
      chip_strobe_ff <= 1'b0;
      epoch_pulse_ff <= 1'b0;
      symbol_take_ff <= 1'b0;
      running_ff     <= 1'b0;
    end else begin
      if (tick) chips_ff <= nxt_chips;            // see [R14]
      else if (!run) chips_ff <= '0;
      chip_strobe_ff <= tick;
      epoch_pulse_ff <= tick && chip_cnt_ff == '0; // see [R20]
      symbol_take_ff <= in_load || (tick && epoch_end && ovl_end);
      running_ff     <= run;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Chips seen since the last epoch pulse
  logic [CNT_W-1:0] gap_ff;
  logic             seen_ep_ff;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gap_ff     <= '0;
      seen_ep_ff <= 1'b0;
    end else if (!run) begin
      gap_ff     <= '0;
      seen_ep_ff <= 1'b0;
    end else if (epoch_pulse_ff) begin
      gap_ff     <= '0;
      seen_ep_ff <= 1'b1;
    end else if (chip_strobe_ff) begin
      gap_ff     <= gap_ff + 1'b1;
    end
  end

  chk_code_xor_out: assert property ( // see [R1]
    tick |=> chips_ff.inphase_ranging_code == $past(xa_out ^ xbi_out)
      && chips_ff.quadrature_ranging_code == $past(xa_out ^ xbq_out))
    else $error("ranging chip is not common xor variant");

  chk_shift_dir: assert property ( // see [R9]
    tick && !xa_load |=> xa_st[12:1] == $past(xa_st[11:0]))
    else $error("common register did not shift up one stage");

  chk_xa_cut: assert property ( // see [R3]
    tick && xa_end && !epoch_end |=> xa_st == ALL_ONES && xa_cnt_ff == '0)
    else $error("common register not cut short");

  chk_epoch_period: assert property ( // see [R4]
    epoch_pulse_ff && seen_ep_ff |-> gap_ff == CNT_W'(EPOCH_LEN - 1))
    else $error("epoch period is not the full chip count");

  chk_variant_reload: assert property ( // see [R6]
    tick && epoch_end |=> xbi_st == b0i_ff && xbq_st == b0q_ff)
    else $error("variant register not reloaded at epoch");

  chk_nav_overlay: assert property ( // see [R12]
    tick |=> (chips_ff.inphase_bit_train ^ chips_ff.inphase_ranging_code)
      == $past(sym_ff ^ ovl_bit))
    else $error("inphase data overlay wrong");

  chk_quad_sync: assert property ( // see [R13]
    tick |=> (chips_ff.quad_bit_train ^ chips_ff.quadrature_ranging_code)
      == $past(qs_bit))
    else $error("quadrature sync overlay wrong");

  chk_sync_align: assert property ( // see [R17]
    run && qs_cnt_ff == '0 |-> ovl_cnt_ff == '0)
    else $error("quadrature sync not on data bit epoch");

  chk_epoch_strobe: assert property ( // see [R20]
    epoch_pulse_ff |-> chip_strobe_ff ##1 !epoch_pulse_ff)
    else $error("epoch pulse not a single chip-aligned cycle");

  chk_chip_edges: assert property ( // see [R14]
    $changed(chips_ff) && running_ff |-> chip_strobe_ff)
    else $error("chip outputs changed off the chip edge");

  cov_epoch:     cover property (epoch_pulse_ff && seen_ep_ff);
  cov_xa_cut:    cover property (tick && xa_end);
  cov_symbol:    cover property (tick && epoch_end && ovl_end);
  cov_seek_done: cover property (seek_done);

endmodule // rcg_top

`default_nettype wire

/* File: verilog/rcg_pkg.sv */
// Constants and types shared by the ranging code generator.
// Assumes a single 25 MHz clock with the chip rate derived from it.
//
// Overview of operation
// [R1] Ranging chip is common XOR variant output
// [R2] All three registers advance once per chip
// [R3] Common register starts all ones, cut at 8190
// [R4] Common register reloads each 1 ms epoch
// [R5] Variant registers wrap freely over 8191 chips
// [R6] Variant registers reload their vector each epoch
// [R7] Fixed feedback polynomials for common and variant
// [R8] Variant set by vector or ones plus advance
// [R9] Shift low to high stage, stage 13 out
// [R10] Common state 8190 detected, reload thirteen ones
// [R11] Encoded nav symbols XORed onto inphase code
// [R12] Ten-bit overlay stepped per epoch on symbols
// [R13] Quadrature code XORed with 20-bit sync code
// [R14] Inphase and quadrature chip edges coincide
// [R15] All timing derived from one clock reference
// [R16] Overlay 0000110101, inverted for one symbols
// [R17] Quadrature sync starts on 20 ms data epoch
// [R18] Rightmost printed vector bit is first chip
// [R19] Satellite selection supplied before enabling
// [R20] One-cycle pulse at each epoch reload
`default_nettype none

package rcg_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_HZ       = 25_000_000;
  localparam int CHIP_HZ      = 10_230_000;
  localparam int NCO_W        = 32;
  localparam logic [NCO_W-1:0] NCO_INC =
    NCO_W'((64'(CHIP_HZ) << NCO_W) / 64'(CLK_HZ));

  // ==========================================================
  // Code lengths
  localparam int EPOCH_CHIPS  = 10230;
  localparam int XA_LEN       = 8190;
  localparam int XB_LEN       = 8191;
  localparam int OVL_LEN      = 10;
  localparam int QSYNC_LEN    = 20;
  localparam int CNT_W        = 14;

  // ==========================================================
  // Feedback taps, bit k-1 is stage k
  localparam logic [12:0] XA_TAPS   = 13'h1B00;
  localparam logic [12:0] XB_TAPS   = 13'h18ED;
  localparam logic [12:0] ALL_ONES  = 13'h1FFF;

  // ==========================================================
  // Synchronisation patterns, first bit is the MSB
  localparam logic [9:0]  OVL_PATTERN   = 10'h035;
  localparam logic [19:0] QSYNC_PATTERN = 20'h04D4E;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    RCG_IDLE = 2'b00,
    RCG_SEEK = 2'b01,
    RCG_LOAD = 2'b10,
    RCG_RUN  = 2'b11
  } rcg_state_t;

  typedef struct packed {
    logic        use_advance;
    logic [12:0] inphase_vec;
    logic [12:0] quad_vec;
    logic [12:0] inphase_adv;
    logic [12:0] quad_adv;
  } rcg_sat_t;

  typedef struct packed {
    logic inphase_ranging_code;
    logic quadrature_ranging_code;
    logic inphase_bit_train;
    logic quad_bit_train;
  } rcg_chip_t;

endpackage

`default_nettype wire

/* File: verilog/rcg_lfsr13.sv */
// Thirteen-stage shift register generator with load and step.
// Assumes load and step come from logic on the same clock.
`default_nettype none

module rcg_lfsr13
  import rcg_pkg::*;
#(
  parameter logic [12:0] TAPS = XB_TAPS
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Control
  input  wire logic        load,
  input  wire logic [12:0] load_state,
  input  wire logic        step,
  // State, bit k-1 is stage k
  output logic      [12:0] state_ff,
  output logic             code_out
);

  // Feedback into stage 1 from the tapped stages
  wire logic fb = ^(state_ff & TAPS);             // see [R7]
  wire logic [12:0] nxt_state = {state_ff[11:0], fb}; // see [R9]

  // Load wins over step so an epoch reload is never skipped
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ALL_ONES;
    end else if (load) begin
      state_ff <= load_state;
    end else if (step) begin
      state_ff <= nxt_state;                      // see [R2]
    end
  end

  assign code_out = state_ff[12];                 // see [R9]

endmodule // rcg_lfsr13

`default_nettype wire

/* File: bench/rcg_nav_source.sv */
// Navigation data source model: feeds encoded symbols to the generator.
// Assumes the generator flags each latched symbol with symbol_take_ff.
`default_nettype none

module rcg_nav_source #(
  parameter logic [7:0] SYMS = 8'hB2
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Generator side
  input  wire logic       symbol_take_ff,
  output logic            nav_bit_train,
  // Symbol index, shown to the bench
  output logic      [7:0] sym_idx
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // Symbol stream
  // Move on only after a take, so the sampled level never slides
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sym_idx <= 8'h00;
    end else if (symbol_take_ff) begin
      sym_idx <= sym_idx + 8'h01;
    end
  end

  // One encoded symbol held for each ten epochs
  assign nav_bit_train = SYMS[sym_idx[2:0]];
endmodule // rcg_nav_source

`default_nettype wire

/* File: bench/rcg_top_tb.sv */
// Self-checking bench for the ranging code generator top.
// Assumes the package constants and a shortened epoch of 300 chips.
`default_nettype none

module rcg_top_tb
  import rcg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // Settings and signals
  localparam int         EP      = 300;
  localparam int         CUT     = 200;
  localparam logic [7:0] SYM_PAT = 8'hB2;
  logic        clk             = 1'b0;
  logic        reset_n         = 1'b0;
  logic        gen_enable      = 1'b0;
  rcg_sat_t    sat_sel         = '0;
  logic        nav_bit_train;
  logic        symbol_take_ff;
  logic        chip_strobe_ff;
  logic        epoch_pulse_ff;
  logic        running_ff;
  rcg_chip_t   chips_ff;
  logic [7:0]  sym_idx;
  logic [12:0] xa, xi, xq, b0i, b0q;
  logic [7:0]  base;
  int          err_total       = 0;
  int          samples_checked = 0;
  int          cyc             = 0;

  // Clock at 25 MHz
  always #20 clk = ~clk;

  rcg_top #(.EPOCH_LEN(EP), .XA_CUT(CUT)) DUT (
    .clk(clk), .reset_n(reset_n), .gen_enable(gen_enable),
    .sat_sel(sat_sel), .nav_bit_train(nav_bit_train),
    .symbol_take_ff(symbol_take_ff), .chips_ff(chips_ff),
    .chip_strobe_ff(chip_strobe_ff), .epoch_pulse_ff(epoch_pulse_ff),
    .running_ff(running_ff));

  rcg_nav_source #(.SYMS(SYM_PAT)) SRC (
    .clk(clk), .reset_n(reset_n), .symbol_take_ff(symbol_take_ff),
    .nav_bit_train(nav_bit_train), .sym_idx(sym_idx));

  // ==========================================================
  // Reference model helpers
  // Stage k moves to k+1, feedback enters stage 1
  function automatic logic [12:0] stp(logic [12:0] s, logic [12:0] t);
    return {s[11:0], ^(s & t)};
  endfunction

  // Printed vectors list stage 13 rightmost
  function automatic logic [12:0] rev(logic [12:0] v);
    logic [12:0] r;
    for (int k = 0; k < 13; k++) r[12-k] = v[k];
    return r;
  endfunction

  task automatic cmp_chip(string nm, logic [3:0] e, logic [3:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic cmp_bit(string nm, logic e, logic g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s exp %b got %b", nm, e, g);
    end
  endtask

  // ==========================================================
  // Shared sequences
  // Work out the start states, then enable with a valid selection
  task automatic start(rcg_sat_t s);
    logic [12:0] a;
    b0i = rev(s.inphase_vec);
    b0q = rev(s.quad_vec);
    if (s.use_advance) begin
      a = ALL_ONES;
      for (int k = 0; k < int'(s.inphase_adv); k++) a = stp(a, XB_TAPS);
      b0i = a;
      a = ALL_ONES;
      for (int k = 0; k < int'(s.quad_adv); k++) a = stp(a, XB_TAPS);
      b0q = a;
    end
    base = sym_idx;
    @(posedge clk);
    gen_enable <= 1'b1;
    sat_sel    <= s;
    @(posedge clk);
    sat_sel    <= ~s; // Must be ignored once taken
  endtask

  // Check n chips against the model, with strobe spacing
  task automatic run(int n);
    int gap, e, j, xc;
    logic [3:0] ex;
    xc = 0;
    for (int c = 0; c < n; c++) begin
      gap = 0;
      do begin
        @(negedge clk);
        gap++;
      end while (chip_strobe_ff !== 1'b1 && gap < 200);
      e = c / EP;
      j = c % EP;
      if (j == 0) begin
        xa = ALL_ONES;
        xi = b0i;
        xq = b0q;
        xc = 0;
      end else begin
        xc++;
        xa = (xc == CUT) ? ALL_ONES : stp(xa, XA_TAPS);
        if (xc == CUT) xc = 0;
        xi = stp(xi, XB_TAPS);
        xq = stp(xq, XB_TAPS);
      end
      ex[3] = xa[12] ^ xi[12];
      ex[2] = xa[12] ^ xq[12];
      ex[1] = ex[3] ^ SYM_PAT[(base + e / 10) % 8] ^ OVL_PATTERN[9 - e % 10];
      ex[0] = ex[2] ^ QSYNC_PATTERN[19 - e % 20];
      cmp_chip("chips", ex, chips_ff);
      cmp_bit("ovl", ex[1] ^ ex[3], chips_ff[1] ^ chips_ff[3]);
      cmp_bit("qsync", ex[0] ^ ex[2], chips_ff[0] ^ chips_ff[2]);
      cmp_bit("epoch", j == 0, epoch_pulse_ff);
      // A new symbol is latched as every tenth epoch closes
      cmp_bit("take", j == EP - 1 && e % 10 == 9, symbol_take_ff);
      if (c > 0) begin
        cmp_bit("spacing", 1'b1, gap == 2 || gap == 3);
      end
    end
    cmp_bit("running", 1'b1, running_ff);
  endtask

  // Drop the enable and expect quiet outputs
  task automatic stop();
    @(posedge clk);
    gen_enable <= 1'b0;
    repeat (4) @(negedge clk);
    cmp_chip("idle chips", 4'h0, chips_ff);
    cmp_bit("idle running", 1'b0, running_ff);
    cmp_bit("idle strobe", 1'b0, chip_strobe_ff);
  endtask

  // ==========================================================
  // Scenarios
  // Long run: symbol changes and a full quadrature sync cycle
  task automatic t_direct();
    rcg_sat_t s;
    s = '0;
    s.inphase_vec = 13'h1A6D;
    s.quad_vec    = 13'h089B;
    start(s);
    run(22 * EP);
    stop();
    $display("test direct done");
  endtask

  // Start states reached by stepping from all ones
  task automatic t_advance();
    rcg_sat_t s;
    s = '0;
    s.use_advance = 1'b1;
    s.inphase_vec = 13'h0F0F;
    s.inphase_adv = 13'h0005;
    s.quad_adv    = 13'h0021;
    start(s);
    run(2 * EP);
    stop();
    $display("test advance done");
  endtask

  // Abort mid-epoch, then a fresh start must begin at chip 0
  task automatic t_abort();
    rcg_sat_t s;
    s = '0;
    s.inphase_vec = 13'h1ABC;
    s.quad_vec    = 13'h0123;
    start(s);
    run(EP / 2);
    stop();
    s.inphase_vec = 13'h0555;
    start(s);
    run(EP + 5);
    stop();
    $display("test abort done");
  endtask

  // ==========================================================
  // Closing and watchdog
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Whole run needs about 19000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      tally_and_finish();
    end
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    t_direct();
    t_advance();
    t_abort();
    tally_and_finish();
  end
endmodule // rcg_top_tb

`default_nettype wire
